// File: src/dmr_top.sv
// request merging, event flags and channel control registers
//
// Contract
// RULE_01 - OR all requests of a channel together
// RULE_02 - system enables one source per channel
// RULE_03 - ch0: converter, timer a cmp2, timer c cmp0
// RULE_04 - ch1..6: serial c, a, b as mapped
// RULE_05 - second: ch2/3 converter outs, timer, serial d
// RULE_06 - second controller has only five channels
// RULE_07 - flag word at 0x00, four bits per channel
// RULE_08 - flags hardware set, cleared only via clear
// RULE_09 - transfer error sets error flag
// RULE_10 - half the transfers sets half-done flag
// RULE_11 - finished sequence sets full-done flag
// RULE_12 - any flag reads as OR of three
// RULE_13 - write-one clear register at 0x04
// RULE_14 - any-clear bit clears all channel flags
// RULE_15 - software keeps reserved top bits zero
// RULE_16 - control at 0x08 + 0x14 * channel
// RULE_17 - control low bits: enable, irq enables, mode
// RULE_18 - m2m, priority, sizes in upper control bits
// RULE_19 - setup fields locked while channel enabled
// RULE_20 - size and priority encodings
// RULE_21 - direction meaning, bit 7 memory increment
// RULE_22 - channel irq from enabled set flags
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module dmr_top import dmr_pkg::*; #(
  parameter bit IS_SECOND = 1'b0 // 0 first controller, 1 second
) (
  input  logic                       sys_clk,  // 40 MHz clock
  input  logic                       arst_n,   // async reset
  // register port
  input  logic [ADDR_W-1:0]          reg_addr, // byte address
  input  logic [31:0]                reg_wdata,// write data
  input  logic                       reg_wr,   // write strobe
  input  logic                       reg_rd,   // read strobe
  output logic [31:0]                reg_rdata_r, // read data
  // peripheral request pins
  input  logic analog_converter_request,       // ch0 first
  input  logic gp_timer_a_compare2_request,    // ch0 first
  input  logic gp_timer_c_compare0_request,    // ch0 first
  input  logic serial_c_transmit_request,      // ch1 first
  input  logic serial_c_receive_request,       // ch2 first
  input  logic serial_a_transmit_request,      // ch3 first
  input  logic serial_a_receive_request,       // ch4 first
  input  logic serial_b_receive_request,       // ch5 first
  input  logic serial_b_transmit_request,      // ch6 first
  input  logic converter_out0_request,         // ch2 second
  input  logic converter_out1_request,         // ch3 second
  input  logic basic_timer_a_update_request,   // ch2 second
  input  logic serial_d_receive_request,       // ch2 second
  input  logic [MAX_CH-1:0]          extra_req,   // other sources
  // engine side
  input  logic [MAX_CH-1:0]          xfer_err_evt,  // error pulse
  input  logic [MAX_CH-1:0]          half_done_evt, // half pulse
  input  logic [MAX_CH-1:0]          full_done_evt, // done pulse
  output logic [MAX_CH-1:0]          chan_req_r,  // merged request
  output logic [MAX_CH-1:0]          chan_irq_r,  // channel irq
  output logic [MAX_CH-1:0][CTL_W-1:0] chan_ctl_r // control words
);

  localparam int NCH = IS_SECOND ? SECOND_NCH : MAX_CH; // RULE_06

  // position of one channel field in the flag and clear words
  function automatic int fpos(input int ch, input int fld);
    fpos = ch * FLAG_STRIDE + fld;
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_r;
  logic rst_n_r;

  // two stages: no flop leaves reset mid-edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ****************************************************************
  // request pin synchronisers
  // ****************************************************************
  // pins are asynchronous: two stages first
  logic [RQ_W-1:0] rq_raw;
  logic [RQ_W-1:0] rq_meta_r;
  logic [RQ_W-1:0] rq_sync_r;

  always_comb begin
    rq_raw             = '0;
    rq_raw[RQ_ADC]     = analog_converter_request;
    rq_raw[RQ_TA_CMP2] = gp_timer_a_compare2_request;
    rq_raw[RQ_TC_CMP0] = gp_timer_c_compare0_request;
    rq_raw[RQ_SC_TX]   = serial_c_transmit_request;
    rq_raw[RQ_SC_RX]   = serial_c_receive_request;
    rq_raw[RQ_SA_TX]   = serial_a_transmit_request;
    rq_raw[RQ_SA_RX]   = serial_a_receive_request;
    rq_raw[RQ_SB_RX]   = serial_b_receive_request;
    rq_raw[RQ_SB_TX]   = serial_b_transmit_request;
    rq_raw[RQ_CO0]     = converter_out0_request;
    rq_raw[RQ_CO1]     = converter_out1_request;
    rq_raw[RQ_BTA_UP]  = basic_timer_a_update_request;
    rq_raw[RQ_SD_RX]   = serial_d_receive_request;
    rq_raw[RQ_EXTRA +: MAX_CH] = extra_req;
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rq_meta_r <= '0;
      rq_sync_r <= '0;
    end else begin
      rq_meta_r <= rq_raw;
      rq_sync_r <= rq_meta_r;
    end
  end

  // ****************************************************************
  // request merge per channel
  // ****************************************************************
  // several live sources on one channel are not arbitrated here;
  // the system keeps one enabled at a time
  logic [MAX_CH-1:0] req_nxt;

  always_comb begin
    req_nxt = rq_sync_r[RQ_EXTRA +: MAX_CH]; // RULE_01 RULE_02
    if (!IS_SECOND) begin
      req_nxt[0] = req_nxt[0] | rq_sync_r[RQ_ADC]
                 | rq_sync_r[RQ_TA_CMP2]
                 | rq_sync_r[RQ_TC_CMP0]; // RULE_03
      req_nxt[1] = req_nxt[1] | rq_sync_r[RQ_SC_TX]; // RULE_04
      req_nxt[2] = req_nxt[2] | rq_sync_r[RQ_SC_RX]; // RULE_04
      req_nxt[3] = req_nxt[3] | rq_sync_r[RQ_SA_TX]; // RULE_04
      req_nxt[4] = req_nxt[4] | rq_sync_r[RQ_SA_RX]; // RULE_04
      req_nxt[5] = req_nxt[5] | rq_sync_r[RQ_SB_RX]; // RULE_04
      req_nxt[6] = req_nxt[6] | rq_sync_r[RQ_SB_TX]; // RULE_04
    end else begin
      req_nxt[2] = req_nxt[2] | rq_sync_r[RQ_CO0]
                 | rq_sync_r[RQ_BTA_UP]
                 | rq_sync_r[RQ_SD_RX]; // RULE_05
      req_nxt[3] = req_nxt[3] | rq_sync_r[RQ_CO1]; // RULE_05
    end
    for (int ch = 0; ch < MAX_CH; ch++) begin
      if (ch >= NCH) begin
        req_nxt[ch] = 1'b0; // RULE_06
      end
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic              hit_flags;
  logic              hit_clear;
  logic [MAX_CH-1:0] hit_ctl;

  always_comb begin
    hit_flags = (reg_addr == OFS_FLAGS); // RULE_07
    hit_clear = (reg_addr == OFS_CLEAR); // RULE_13
    for (int ch = 0; ch < MAX_CH; ch++) begin
      hit_ctl[ch] = (ch < NCH) && (reg_addr == ctl_addr(ch)); // RULE_16
    end
  end

  // ****************************************************************
  // register strobes
  // ****************************************************************
  logic              wr_clear;
  logic [MAX_CH-1:0] wr_ctl;
  logic              rd_flags;
  logic [MAX_CH-1:0] rd_ctl;

  always_comb begin
    wr_clear = reg_wr && hit_clear; // RULE_13
    rd_flags = reg_rd && hit_flags; // RULE_07
    for (int ch = 0; ch < MAX_CH; ch++) begin
      wr_ctl[ch] = reg_wr && hit_ctl[ch]; // RULE_16
      rd_ctl[ch] = reg_rd && hit_ctl[ch]; // RULE_16
    end
  end

  // ****************************************************************
  // flag bank
  // ****************************************************************
  // engine events share this clock: no sync
  dmr_ev_if ev ();

  assign ev.err_set  = xfer_err_evt;
  assign ev.half_set = half_done_evt;
  assign ev.full_set = full_done_evt;
  // writes to the flag word itself fall through: read only
  assign ev.clr_vld  = wr_clear; // RULE_08 RULE_13
  assign ev.clr_word = reg_wdata;

  dmr_flag_bank #(
    .NCH (NCH)
  ) u_flags (
    .clk   (sys_clk),
    .rst_n (rst_n_r),
    .ev    (ev)
  );

  logic [31:0] flag_word;

  always_comb begin
    flag_word = FLAGS_RST; // reserved top nibble stays zero
    for (int ch = 0; ch < MAX_CH; ch++) begin
      flag_word[fpos(ch, FB_ERR)]  = ev.err_q[ch];  // RULE_07
      flag_word[fpos(ch, FB_HALF)] = ev.half_q[ch]; // RULE_07
      flag_word[fpos(ch, FB_FULL)] = ev.full_q[ch]; // RULE_07
      flag_word[fpos(ch, FB_ANY)]  = ev.err_q[ch]
                                   | ev.half_q[ch]
                                   | ev.full_q[ch]; // RULE_12
    end
  end

  // ****************************************************************
  // channel control registers
  // ****************************************************************
  // size fields keep the reserved code 2'h3 as written; the engine
  // must treat it as invalid, priority uses all four codes
  logic [MAX_CH-1:0][CTL_W-1:0] ctl_q;

  for (genvar g = 0; g < MAX_CH; g++) begin : g_ctl
    if (g < NCH) begin : g_on
      dmr_ctl_reg u_ctl (
        .clk   (sys_clk),
        .rst_n (rst_n_r),
        .wr_en (wr_ctl[g]),
        .wdata (reg_wdata[CTL_W-1:0]),
        .ctl_r (ctl_q[g])
      ); // RULE_17 RULE_18 RULE_19 RULE_20 RULE_21
    end else begin : g_off
      assign ctl_q[g] = CTL_RST; // RULE_06
    end
  end

  assign chan_ctl_r = ctl_q;

  // ****************************************************************
  // channel interrupts
  // ****************************************************************
  logic [MAX_CH-1:0] err_ie;
  logic [MAX_CH-1:0] half_ie;
  logic [MAX_CH-1:0] full_ie;
  logic [MAX_CH-1:0] irq_nxt;

  // enables come from the stored word, so a write
  // that sets one raises the irq a cycle later
  always_comb begin
    for (int ch = 0; ch < MAX_CH; ch++) begin
      err_ie[ch]  = ctl_q[ch][CB_ERR_IE];
      half_ie[ch] = ctl_q[ch][CB_HALF_IE];
      full_ie[ch] = ctl_q[ch][CB_FULL_IE];
    end
  end

  always_comb begin
    for (int ch = 0; ch < MAX_CH; ch++) begin
      irq_nxt[ch] = (ev.err_q[ch]  && err_ie[ch])
                  | (ev.half_q[ch] && half_ie[ch])
                  | (ev.full_q[ch] && full_ie[ch]); // RULE_22
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  // clear word and unmapped addresses read zero, one cycle later
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = '0;
    if (rd_flags) begin
      rdata_nxt = flag_word; // RULE_07 RULE_12
    end
    for (int ch = 0; ch < MAX_CH; ch++) begin
      if (rd_ctl[ch]) begin
        rdata_nxt = {16'h0000, ctl_q[ch]}; // RULE_16
      end
    end
  end

  // ****************************************************************
  // output registers
  // registered so no glitch reaches the engine
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_r <= '0;
      chan_req_r  <= '0;
      chan_irq_r  <= '0;
    end else begin
      reg_rdata_r <= rdata_nxt;
      chan_req_r  <= req_nxt;
      chan_irq_r  <= irq_nxt;
    end
  end

endmodule

// File: src/dmr_pkg.sv
// constants and helpers shared by the request and flag register block
package dmr_pkg;

  // ****************************************************************
  // channel counts
  // ****************************************************************
  localparam int MAX_CH     = 7;
  localparam int SECOND_NCH = 5;
  localparam int CTL_W      = 16;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int        ADDR_W       = 8;
  localparam logic [7:0] OFS_FLAGS    = 8'h00;
  localparam logic [7:0] OFS_CLEAR    = 8'h04;
  localparam logic [7:0] OFS_CTL_BASE = 8'h08;
  localparam logic [7:0] OFS_CH_STEP  = 8'h14;
  localparam logic [31:0] FLAGS_RST   = 32'h0000_0000;
  localparam logic [15:0] CTL_RST     = 16'h0000;

  // ****************************************************************
  // flag and clear field layout, four bits per channel
  // ****************************************************************
  localparam int FLAG_STRIDE = 4;
  localparam int FB_ANY      = 0;
  localparam int FB_FULL     = 1;
  localparam int FB_HALF     = 2;
  localparam int FB_ERR      = 3;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CB_ON      = 0;
  localparam int CB_FULL_IE = 1;
  localparam int CB_HALF_IE = 2;
  localparam int CB_ERR_IE  = 3;
  localparam int CB_DIR     = 4;
  localparam int CB_CIRC    = 5;
  localparam int CB_PINC    = 6;
  localparam int CB_MINC    = 7;
  localparam int CB_PSIZE   = 8;
  localparam int CB_MSIZE   = 10;
  localparam int CB_CHANNEL_PRIORITY    = 12;
  localparam int CB_M2M     = 14;
  // writable while the channel runs: enable and irq enables
  localparam logic [15:0] CTL_LIVE_MASK = 16'h000f;
  // bit 15 reserved
  localparam logic [15:0] CTL_IMPL_MASK = 16'h7fff;

  typedef enum logic [1:0] {
    DMR_SZ_8   = 2'h0,
    DMR_SZ_16  = 2'h1,
    DMR_SZ_32  = 2'h2,
    DMR_SZ_RSV = 2'h3
  } dmr_size_type;

  typedef enum logic [1:0] {
    DMR_PR_LOW   = 2'h0,
    DMR_PR_MED   = 2'h1,
    DMR_PR_HIGH  = 2'h2,
    DMR_PR_ULTRA = 2'h3
  } dmr_channel_priority_type;

  // ****************************************************************
  // raw request pin positions before synchronisation
  // ****************************************************************
  localparam int RQ_ADC      = 0;
  localparam int RQ_TA_CMP2  = 1;
  localparam int RQ_TC_CMP0  = 2;
  localparam int RQ_SC_TX    = 3;
  localparam int RQ_SC_RX    = 4;
  localparam int RQ_SA_TX    = 5;
  localparam int RQ_SA_RX    = 6;
  localparam int RQ_SB_RX    = 7;
  localparam int RQ_SB_TX    = 8;
  localparam int RQ_CO0      = 9;
  localparam int RQ_CO1      = 10;
  localparam int RQ_BTA_UP   = 11;
  localparam int RQ_SD_RX    = 12;
  localparam int RQ_EXTRA    = 13;
  localparam int RQ_W        = RQ_EXTRA + MAX_CH;

  // control register byte address of a channel
  function automatic logic [7:0] ctl_addr(input int ch);
    ctl_addr = OFS_CTL_BASE + 8'(ch) * OFS_CH_STEP;
  endfunction

endpackage

// File: src/dmr_ev_if.sv
// link between the register core and the channel flag bank
`timescale 1ns/10ps
interface dmr_ev_if;
  import dmr_pkg::*;
  logic [MAX_CH-1:0] err_set;
  logic [MAX_CH-1:0] half_set;
  logic [MAX_CH-1:0] full_set;
  logic              clr_vld;
  logic [31:0]       clr_word;
  logic [MAX_CH-1:0] err_q;
  logic [MAX_CH-1:0] half_q;
  logic [MAX_CH-1:0] full_q;

  modport bank (
    input  err_set, half_set, full_set, clr_vld, clr_word,
    output err_q, half_q, full_q
  );
  modport core (
    output err_set, half_set, full_set, clr_vld, clr_word,
    input  err_q, half_q, full_q
  );
endinterface

// File: src/dmr_flag_bank.sv
// sticky per-channel event flags with write-one clear
`timescale 1ns/10ps
module dmr_flag_bank import dmr_pkg::*; #(
  parameter int NCH = MAX_CH
) (
  input  logic   clk,   // system clock
  input  logic   rst_n, // synchronised reset, active low
  dmr_ev_if.bank ev     // events in, flags out
);

  logic [MAX_CH-1:0] err_r,  err_nxt;
  logic [MAX_CH-1:0] half_r, half_nxt;
  logic [MAX_CH-1:0] full_r, full_nxt;

  always_comb begin
    err_nxt  = err_r;
    half_nxt = half_r;
    full_nxt = full_r;
    for (int ch = 0; ch < MAX_CH; ch++) begin
      if (ch < NCH) begin
        // clear first, then set: an event in the clear cycle survives
        if (ev.clr_vld) begin
          if (ev.clr_word[ch*FLAG_STRIDE+FB_ERR] ||
              ev.clr_word[ch*FLAG_STRIDE+FB_ANY]) begin
            err_nxt[ch] = 1'b0; // RULE_13 RULE_14
          end
          if (ev.clr_word[ch*FLAG_STRIDE+FB_HALF] ||
              ev.clr_word[ch*FLAG_STRIDE+FB_ANY]) begin
            half_nxt[ch] = 1'b0; // RULE_13 RULE_14
          end
          if (ev.clr_word[ch*FLAG_STRIDE+FB_FULL] ||
              ev.clr_word[ch*FLAG_STRIDE+FB_ANY]) begin
            full_nxt[ch] = 1'b0; // RULE_13 RULE_14
          end
        end
        if (ev.err_set[ch]) begin
          err_nxt[ch] = 1'b1; // RULE_09 RULE_08
        end
        if (ev.half_set[ch]) begin
          half_nxt[ch] = 1'b1; // RULE_10 RULE_08
        end
        if (ev.full_set[ch]) begin
          full_nxt[ch] = 1'b1; // RULE_11 RULE_08
        end
      end else begin
        // missing channels hold no state
        err_nxt[ch]  = 1'b0; // RULE_06
        half_nxt[ch] = 1'b0;
        full_nxt[ch] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_r  <= '0;
      half_r <= '0;
      full_r <= '0;
    end else begin
      err_r  <= err_nxt;
      half_r <= half_nxt;
      full_r <= full_nxt;
    end
  end

  assign ev.err_q  = err_r;
  assign ev.half_q = half_r;
  assign ev.full_q = full_r;

endmodule

// File: src/dmr_ctl_reg.sv
// one channel control register with run-time write protection
`timescale 1ns/10ps
module dmr_ctl_reg import dmr_pkg::*; (
  input  logic              clk,   // system clock
  input  logic              rst_n, // synchronised reset, active low
  input  logic              wr_en, // write hits this register
  input  logic [CTL_W-1:0]  wdata, // write data, low half
  output logic [CTL_W-1:0]  ctl_r  // stored control word
);

  logic [CTL_W-1:0] ctl_nxt;
  logic [CTL_W-1:0] keep_mask;

  always_comb begin
    // while running only enable and irq enables move
    keep_mask = ctl_r[CB_ON] ? CTL_LIVE_MASK : CTL_IMPL_MASK; // RULE_19
    ctl_nxt   = ctl_r;
    if (wr_en) begin
      ctl_nxt = (ctl_r & ~keep_mask) | (wdata & keep_mask); // RULE_17 RULE_18
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= CTL_RST; // RULE_16
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

endmodule

// File: sim/dmr_top_props.sv
// concurrent checks on the request and flag register block ports
`timescale 1ns/10ps
module dmr_top_props import dmr_pkg::*; (
  input logic                         sys_clk,     // clock
  input logic                         arst_n,      // async reset
  input logic [ADDR_W-1:0]            reg_addr,    // byte address
  input logic [31:0]                  reg_wdata,   // write data
  input logic                         reg_wr,      // write strobe
  input logic                         reg_rd,      // read strobe
  input logic [31:0]                  reg_rdata_r, // read data
  input logic                         analog_converter_request, // ch0
  input logic                         serial_b_transmit_request, // ch6
  input logic [MAX_CH-1:0]            extra_req,   // other sources
  input logic [MAX_CH-1:0]            full_done_evt, // done pulses
  input logic [MAX_CH-1:0]            chan_req_r,  // merged requests
  input logic [MAX_CH-1:0]            chan_irq_r,  // channel irqs
  input logic [MAX_CH-1:0][CTL_W-1:0] chan_ctl_r   // control words
);
  logic              any_ok;
  logic              top_clear;
  logic [MAX_CH-1:0] ie_any;

  // judged on whatever the data lines carry, so only flag word reads matter
  always_comb begin
    any_ok    = 1'b1;
    top_clear = 1'b1;
    for (int c = 0; c < MAX_CH; c++) begin
      if (reg_rdata_r[4*c] != |reg_rdata_r[4*c+1 +: 3]) any_ok = 1'b0;
      if (chan_ctl_r[c][15]) top_clear = 1'b0;
      ie_any[c] = |chan_ctl_r[c][3:1];
    end
  end

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_any_is_or: assert property (
    reg_rd && reg_addr == OFS_FLAGS |=> any_ok)
    else $error("any flag differs from its event flags");
  chk_flags_top: assert property (
    reg_rd && reg_addr == OFS_FLAGS |=> reg_rdata_r[31:28] == 4'h0)
    else $error("flag word top bits not zero");
  chk_irq_full: assert property (
    full_done_evt[0] && chan_ctl_r[0][CB_FULL_IE] && !reg_wr ##1 !reg_wr
    |=> chan_irq_r[0])
    else $error("enabled done event gave no irq");
  chk_irq_gated: assert property (
    (chan_irq_r & ~$past(ie_any)) == 7'h00)
    else $error("irq raised without any enable");
  chk_lock_fields: assert property (
    reg_wr && chan_ctl_r[2][CB_ON]
    |=> chan_ctl_r[2][15:4] == $past(chan_ctl_r[2][15:4]))
    else $error("locked control field changed");
  chk_ctl_store: assert property (
    reg_wr && reg_addr == 8'h1c && !chan_ctl_r[1][CB_ON]
    |=> chan_ctl_r[1] == (16'($past(reg_wdata)) & 16'h7fff))
    else $error("control write not stored");
  chk_bit15_zero: assert property (top_clear)
    else $error("reserved control bit set");
  chk_req_adc: assert property (
    analog_converter_request |-> ##3 chan_req_r[0])
    else $error("channel zero request missing");
  chk_req_idle: assert property (
    !serial_b_transmit_request && !extra_req[6] |-> ##3 !chan_req_r[6])
    else $error("channel six request without source");
endmodule

bind dmr_top dmr_top_props u_dmr_top_props (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r),
  .analog_converter_request(analog_converter_request),
  .serial_b_transmit_request(serial_b_transmit_request),
  .extra_req(extra_req), .full_done_evt(full_done_evt),
  .chan_req_r(chan_req_r), .chan_irq_r(chan_irq_r),
  .chan_ctl_r(chan_ctl_r)
);

// File: sim/dmr_periph_model.sv
// peripheral side: raises at most one request source at a time
`timescale 1ns/10ps
module dmr_periph_model import dmr_pkg::*; (
  input  logic                sys_clk,  // system clock
  input  logic [4:0]          src_sel,  // 0 none, else source plus one
  output logic [RQ_EXTRA-1:0] req_pins  // request levels
);
  // a single source keeps every channel to one active request
  always @(posedge sys_clk) begin
    req_pins <= (src_sel == 5'h0) ? '0
              : RQ_EXTRA'(1) << (src_sel - 5'h1);
  end
endmodule

// File: sim/dmr_top_tb_top.sv
// self-checking bench for request merging, flags and control words
`timescale 1ns/10ps
module dmr_top_tb_top import dmr_pkg::*; ;
  logic                         sys_clk = 1'b0;
  logic                         arst_n = 1'b0;
  logic [ADDR_W-1:0]            reg_addr = '0;
  logic [31:0]                  reg_wdata = '0;
  logic                         reg_wr = 1'b0;
  logic                         reg_rd = 1'b0;
  logic [31:0]                  reg_rdata_r;
  logic [4:0]                   src_sel = '0;
  logic [RQ_EXTRA-1:0]          pins;
  logic [MAX_CH-1:0]            extra_req = '0;
  logic [MAX_CH-1:0]            evt [3] = '{default: '0};
  logic [MAX_CH-1:0]            chan_req_r;
  logic [MAX_CH-1:0]            chan_irq_r;
  logic [MAX_CH-1:0][CTL_W-1:0] chan_ctl_r;
  int                           bad_count = 0;
  int                           checks = 0;

  always #12.5 sys_clk = ~sys_clk;

  dmr_periph_model u_dmr_periph_model (
    .sys_clk(sys_clk), .src_sel(src_sel), .req_pins(pins));

  dmr_top #(.IS_SECOND(1'b0)) u_dmr_top (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r),
    .analog_converter_request(pins[0]),
    .gp_timer_a_compare2_request(pins[1]),
    .gp_timer_c_compare0_request(pins[2]),
    .serial_c_transmit_request(pins[3]),
    .serial_c_receive_request(pins[4]),
    .serial_a_transmit_request(pins[5]),
    .serial_a_receive_request(pins[6]),
    .serial_b_receive_request(pins[7]),
    .serial_b_transmit_request(pins[8]),
    .converter_out0_request(pins[9]),
    .converter_out1_request(pins[10]),
    .basic_timer_a_update_request(pins[11]),
    .serial_d_receive_request(pins[12]),
    .extra_req(extra_req), .xfer_err_evt(evt[0]),
    .half_done_evt(evt[1]), .full_done_evt(evt[2]),
    .chan_req_r(chan_req_r), .chan_irq_r(chan_irq_r),
    .chan_ctl_r(chan_ctl_r));

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    check(what, reg_rdata_r, exp);
  endtask

  // kind 0 error, 1 half, 2 full
  task automatic pulse(input int k, input logic [MAX_CH-1:0] m);
    @(posedge sys_clk);
    evt[k] <= m;
    @(posedge sys_clk);
    evt[k] <= '0;
  endtask

  function automatic logic [7:0] cadr(input int c);
    return 8'h08 + 8'(c) * 8'h14;
  endfunction

  // pins 9..12 belong to the second controller only
  function automatic logic [6:0] req_exp(input int i);
    if (i < 3) return 7'h01;
    if (i < 9) return 7'(1 << (i - 2));
    return 7'h00;
  endfunction

  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [15:0] v;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(OFS_FLAGS, 32'h0, "flags reset");
    @(posedge sys_clk);
    #1;
    check("rdata idle", reg_rdata_r, 32'h0);
    rd(OFS_CLEAR, 32'h0, "clear reads zero");
    rd(8'h84, 32'h0, "unmapped");
    for (int c = 0; c < MAX_CH; c++) rd(cadr(c), 32'h0, "ctl rst");
    for (int i = 0; i < RQ_EXTRA; i++) begin
      src_sel <= 5'(i + 1);
      repeat (6) @(posedge sys_clk);
      check("pin request", 32'(chan_req_r), 32'(req_exp(i)));
      src_sel <= 5'h0;
      repeat (6) @(posedge sys_clk);
      check("request drop", 32'(chan_req_r), 32'h0);
    end
    for (int c = 0; c < MAX_CH; c++) begin
      extra_req <= 7'(1 << c);
      repeat (6) @(posedge sys_clk);
      check("extra request", 32'(chan_req_r), 32'(1 << c));
    end
    extra_req <= '0;
    for (int c = 0; c < MAX_CH; c++) begin
      for (int k = 0; k < 3; k++) pulse(k, 7'(1 << c));
      rd(OFS_FLAGS, 32'hf << 4*c, "flags set");
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_CLEAR, 32'h0);
      rd(OFS_FLAGS, 32'hf << 4*c, "flags kept");
      wr(OFS_CLEAR, 32'h8 << 4*c);
      wr(OFS_CLEAR, 32'h4 << 4*c);
      rd(OFS_FLAGS, 32'h3 << 4*c, "flag clear");
      wr(OFS_CLEAR, 32'h1 << 4*c);
      rd(OFS_FLAGS, 32'h0, "all clear");
    end
    for (int c = 0; c < MAX_CH; c++) wr(cadr(c), 32'hffff_fff0 - 32'(c << 4));
    for (int c = 0; c < MAX_CH; c++) begin
      v = 16'h7ff0 - 16'(c << 4);
      rd(cadr(c), {16'h0, v}, "ctl store");
      check("ctl port", 32'(chan_ctl_r[c]), {16'h0, v});
    end
    wr(cadr(2), 32'h0000_0001);
    wr(cadr(2), 32'h0000_5a5e);
    rd(cadr(2), 32'h0000_000e, "ctl locked");
    wr(cadr(2), 32'h0000_5a50);
    rd(cadr(2), 32'h0000_5a50, "ctl unlocked");
    wr(cadr(0), 32'h0000_0002);
    wr(cadr(1), 32'h0000_0000);
    pulse(2, 7'h03);
    repeat (3) @(posedge sys_clk);
    #1;
    check("irq on full", 32'(chan_irq_r), 32'h1);
    pulse(0, 7'h01);
    wr(OFS_CLEAR, 32'h0000_0002);
    repeat (3) @(posedge sys_clk);
    #1;
    check("irq masked err", 32'(chan_irq_r), 32'h0);
    rd(OFS_FLAGS, 32'h0000_0039, "mixed flags");
    complete_run();
  end
endmodule
